//--- logic/pmtd_regs.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module pmtd_regs
    import pmtd_pkg::*;
(
    input  wire logic        sys_clk,                // 100 MHz clock
    input  wire logic        rst_n,                  // Sync reset
    input  wire logic [31:0] s_axi_awaddr,           // Write address
    input  wire logic        s_axi_awvalid,          // Write address valid
    output logic             s_axi_awready,          // Write address ready
    input  wire logic [31:0] s_axi_wdata,            // Write data
    input  wire logic [3:0]  s_axi_wstrb,            // Byte enables
    input  wire logic        s_axi_wvalid,           // Write data valid
    output logic             s_axi_wready,           // Write data ready
    output logic [1:0]       s_axi_bresp,            // Write response
    output logic             s_axi_bvalid,           // Write response valid
    input  wire logic        s_axi_bready,           // Write response ready
    input  wire logic [31:0] s_axi_araddr,           // Read address
    input  wire logic        s_axi_arvalid,          // Read address valid
    output logic             s_axi_arready,          // Read address ready
    output logic [31:0]      s_axi_rdata,            // Read data
    output logic [1:0]       s_axi_rresp,            // Read response
    output logic             s_axi_rvalid,           // Read data valid
    input  wire logic        s_axi_rready,           // Read data ready
    input  wire logic [2:0]  operatingModeField,     // Current operating mode
    output logic [2:0]       activePowerSetting,     // Power setting in use
    output logic             serialHighSpeedEnable,  // Last written enable
    output pmtd_drive_t      drive                   // Test-drive controls
);

    pmtd_regwr_t wr;
    logic        wrEn;
    logic        wrHit;
    logic        rdEn;
    logic        rdHit;
    logic [31:0] rdData;
    logic        wrLane0;
    logic        modeActive;
    logic [2:0]  wakePowerSetting, next_wakePowerSetting;
    logic [2:0]  sniffPowerSetting, next_sniffPowerSetting;
    logic        next_serialHighSpeedEnable;
    logic [2:0]  next_activePowerSetting;
    pmtd_drive_t next_drive;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    pmtd_axil_slave u_slave (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr            (wr),
        .wrEn          (wrEn),
        .wrHit         (wrHit),
        .rdEn          (rdEn),
        .rdData        (rdData),
        .rdHit         (rdHit)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wrHit   = (wr.addr == PWR_CTRL_ADDR) || (wr.addr == XDRV_ADDR)
                  || (wr.addr == YDRV_ADDR);
    assign rdHit   = (s_axi_araddr == PWR_CTRL_ADDR) || (s_axi_araddr == XDRV_ADDR)
                  || (s_axi_araddr == YDRV_ADDR);
    // Registers are one byte wide, so only lane 0 carries them
    assign wrLane0 = wrEn && wr.strb[0];

    // Sleep and standby are the only idle modes
    assign modeActive = (operatingModeField != MODE_SLEEP)
                     && (operatingModeField != MODE_STANDBY);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Reserved bits are not stored; software keeps them fixed
    always_comb begin
        next_wakePowerSetting      = wakePowerSetting;
        next_sniffPowerSetting     = sniffPowerSetting;
        next_serialHighSpeedEnable = serialHighSpeedEnable;
        next_drive                 = drive;
        if (wrLane0) begin
            case (wr.addr)
                PWR_CTRL_ADDR: begin
                    next_wakePowerSetting      = wr.data[WAKE_LSB +: 3];
                    next_sniffPowerSetting     = wr.data[SNIFF_LSB +: 3];
                    next_serialHighSpeedEnable = wr.data[HS_BIT];
                end
                XDRV_ADDR: begin
                    next_drive.xPos = wr.data[POS_BIT];
                    next_drive.xNeg = wr.data[NEG_BIT];
                end
                YDRV_ADDR: begin
                    next_drive.yPos = wr.data[POS_BIT];
                    next_drive.yNeg = wr.data[NEG_BIT];
                end
                default: begin
                    next_drive = drive;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power setting in use
    // ------------------------------------------------------------
    // Idle modes keep the wake setting so the front end is ready to wake
    always_comb begin
        if (operatingModeField == MODE_SNIFF) begin
            next_activePowerSetting = sniffPowerSetting;
        end else begin
            next_activePowerSetting = wakePowerSetting;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wakePowerSetting      <= PWR_SET_RST;
            sniffPowerSetting     <= PWR_SET_RST;
            serialHighSpeedEnable <= 1'b0;
            drive                 <= '0;
            activePowerSetting    <= PWR_SET_RST;
        end else begin
            wakePowerSetting      <= next_wakePowerSetting;
            sniffPowerSetting     <= next_sniffPowerSetting;
            serialHighSpeedEnable <= next_serialHighSpeedEnable;
            drive                 <= next_drive;
            activePowerSetting    <= next_activePowerSetting;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rdData = 32'h00000000;
        case (s_axi_araddr)
            PWR_CTRL_ADDR: begin
                rdData[WAKE_LSB +: 3]  = wakePowerSetting;
                rdData[SNIFF_LSB +: 3] = sniffPowerSetting;
                rdData[HS_BIT]         = 1'b0;
            end
            YDRV_ADDR: begin
                rdData[7:0] = modeActive ? Y_READ_ACTIVE : Y_READ_IDLE;
            end
            default: begin
                rdData = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_wake_field_write: assert property (
        wrLane0 && wr.addr == PWR_CTRL_ADDR |=> wakePowerSetting == $past(wr.data[2:0]))
        else $error("wake power field not written");

    a_sniff_field_write: assert property (
        wrLane0 && wr.addr == PWR_CTRL_ADDR |=> sniffPowerSetting == $past(wr.data[6:4]))
        else $error("sniff power field not written");

    a_reset_low_power: assert property (
        $rose(rst_n) |-> wakePowerSetting == PWR_LOW && sniffPowerSetting == PWR_LOW
                         && activePowerSetting == PWR_LOW)
        else $error("power fields not low power after reset");

    a_sniff_power_applied: assert property (
        operatingModeField == MODE_SNIFF |=> activePowerSetting == $past(sniffPowerSetting))
        else $error("sniff setting not applied in sniff mode");

    a_wake_power_applied: assert property (
        operatingModeField inside {MODE_CONTINUOUS_WAKE_MODE, MODE_SNIFF_WAKE_MODE}
        |=> activePowerSetting == $past(wakePowerSetting))
        else $error("wake setting not applied in wake modes");

    a_hs_reads_zero: assert property (
        rdEn && s_axi_araddr == PWR_CTRL_ADDR ##1 s_axi_rvalid
        |-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[2:0] == $past(wakePowerSetting))
        else $error("high-speed enable bit read back set");

    a_xdrive_write: assert property (
        wrLane0 && wr.addr == XDRV_ADDR
        |=> drive.xPos == $past(wr.data[2]) && drive.xNeg == $past(wr.data[3])
            && $stable(drive.yPos) && $stable(drive.yNeg))
        else $error("X drive bits not taken from write");

    a_ydrive_write: assert property (
        wrLane0 && wr.addr == YDRV_ADDR
        |=> drive.yPos == $past(wr.data[2]) && drive.yNeg == $past(wr.data[3])
            && $stable(drive.xPos) && $stable(drive.xNeg))
        else $error("Y drive bits not taken from write");

    a_yread_by_mode: assert property (
        rdEn && s_axi_araddr == YDRV_ADDR
        |=> s_axi_rvalid && s_axi_rdata == ($past(modeActive) ? 32'h00000080 : 32'h00000000))
        else $error("Y read-back does not follow mode");

    a_write_answer: assert property (
        wrEn |=> s_axi_bvalid && (s_axi_bresp == ($past(wrHit) ? RESP_OKAY : RESP_SLVERR)))
        else $error("write response missing or wrong");

    c_power_write: cover property (
        wrLane0 && wr.addr == PWR_CTRL_ADDR && wr.data[6:4] == PWR_PRECISION);
    c_yread_active: cover property (
        rdEn && s_axi_araddr == YDRV_ADDR && modeActive);
    c_drive_both_axes: cover property (
        drive.xPos && drive.yNeg);
    c_sniff_ultra_low: cover property (
        operatingModeField == MODE_SNIFF && sniffPowerSetting == PWR_ULTRA_LOW);

endmodule

//--- logic/pmtd_pkg.sv
package pmtd_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] PWR_CTRL_IDX = 8'h1C;
    localparam logic [7:0] XDRV_IDX     = 8'h21 - 8'h01;
    localparam logic [7:0] YDRV_IDX     = 8'h21;
    // Byte address is four times the printed index
    localparam logic [31:0] PWR_CTRL_ADDR = {22'h000000, PWR_CTRL_IDX, 2'h0};
    localparam logic [31:0] XDRV_ADDR     = {22'h000000, XDRV_IDX, 2'h0};
    localparam logic [31:0] YDRV_ADDR     = {22'h000000, YDRV_IDX, 2'h0};
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned WAKE_LSB  = 0;
    localparam int unsigned SNIFF_LSB = 4;
    localparam int unsigned HS_BIT    = 7;
    localparam int unsigned POS_BIT   = 2;
    localparam int unsigned NEG_BIT   = 3;
    localparam logic [2:0]  PWR_LOW       = 3'h0;
    localparam logic [2:0]  PWR_ULTRA_LOW = 3'h3;
    localparam logic [2:0]  PWR_PRECISION = 3'h4;
    localparam logic [2:0]  PWR_SET_RST   = PWR_LOW;
    localparam logic [7:0]  Y_READ_ACTIVE = 8'h80;
    localparam logic [7:0]  Y_READ_IDLE   = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SLEEP   = 3'h0,
        MODE_STANDBY = 3'h1,
        MODE_SNIFF   = 3'h2,
        MODE_CONTINUOUS_WAKE_MODE   = 3'h5,
        MODE_SNIFF_WAKE_MODE   = 3'h6,
        MODE_TRIGGERED_SAMPLING_MODE    = 3'h7
    } pmtd_mode_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pmtd_regwr_t;

    typedef struct packed {
        logic xPos;
        logic xNeg;
        logic yPos;
        logic yNeg;
    } pmtd_drive_t;

endpackage

//--- logic/pmtd_axil_slave.sv
`timescale 1ns/1ps
module pmtd_axil_slave
    import pmtd_pkg::*;
(
    input  wire logic        sys_clk,        // System clock
    input  wire logic        rst_n,          // Sync reset
    input  wire logic [31:0] s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [31:0] s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    output pmtd_regwr_t      wr,             // Held write request
    output logic             wrEn,           // Write commit pulse
    input  wire logic        wrHit,          // Write address mapped
    output logic             rdEn,           // Read accept pulse
    input  wire logic [31:0] rdData,         // Read value
    input  wire logic        rdHit           // Read address mapped
);

    logic        awHeld, next_awHeld;
    logic        wHeld, next_wHeld;
    pmtd_regwr_t next_wr;
    logic        next_awready, next_wready, next_arready;
    logic        next_bvalid, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Channel handshakes
    // ------------------------------------------------------------
    // Commit waits for a free response slot, so one write at a time
    assign wrEn = awHeld && wHeld && !s_axi_bvalid;
    assign rdEn = s_axi_arvalid && s_axi_arready;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld  = wHeld;
        next_wr     = wr;
        next_bvalid = s_axi_bvalid;
        next_bresp  = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_wr.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wr.data = s_axi_wdata;
            next_wr.strb = s_axi_wstrb;
        end
        if (wrEn) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rdEn) begin
            next_rvalid = 1'b1;
            next_rdata  = rdData;
            next_rresp  = rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_awHeld;
        next_wready  = !next_wHeld;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            wr            <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
        end else begin
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            wr            <= next_wr;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

endmodule

//--- test/pmtd_regs_test.sv
`timescale 1ns/1ps
module pmtd_regs_test
    import pmtd_pkg::*;
;
    logic        sys_clk;
    logic        rst_n;
    logic [31:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [2:0]  operatingModeField;
    logic [2:0]  activePowerSetting;
    logic        serialHighSpeedEnable;
    pmtd_drive_t drive;
    int          mismatches;
    int          cmpCount;
    logic [31:0] rdVal;
    logic [1:0]  resp;
    logic [2:0]  codes [3] = '{PWR_LOW, PWR_ULTRA_LOW, PWR_PRECISION};
    pmtd_mode_t  modes [6] = '{MODE_SLEEP, MODE_STANDBY, MODE_SNIFF, MODE_CONTINUOUS_WAKE_MODE, MODE_SNIFF_WAKE_MODE, MODE_TRIGGERED_SAMPLING_MODE};

    pmtd_regs u_pmtd_regs (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Readies are sampled at the rising edge itself, where the handshake happens
    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic awPend;
        logic wPend;
        awPend = 1'b1;
        wPend  = 1'b1;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 50 && (awPend || wPend); n++) begin
            @(posedge sys_clk);
            if (awPend && s_axi_awready) begin
                awPend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wPend && s_axi_wready) begin
                wPend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) break;
        end
        s_axi_arvalid <= 1'b0;
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic setMode(input pmtd_mode_t m);
        @(posedge sys_clk);
        operatingModeField <= m;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Drive table: both directions of an axis are never set together
    logic [31:0] drvAddr [6] = '{XDRV_ADDR, XDRV_ADDR, YDRV_ADDR, YDRV_ADDR, XDRV_ADDR, YDRV_ADDR};
    logic [7:0]  drvData [6] = '{8'h05, 8'h09, 8'h84, 8'h88, 8'h01, 8'h80};
    logic [3:0]  drvExp  [6] = '{4'h8, 4'h4, 4'h6, 4'h5, 4'h1, 4'h0};

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        finalReport();
    end

    initial begin
        logic [2:0] wk;
        logic [2:0] sn;
        mismatches = 0;
        cmpCount = 0;
        rst_n = 1'b0;
        s_axi_awaddr = 32'h0000_0000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h0000_0000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        operatingModeField = MODE_SLEEP;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check("aps reset", 32'(activePowerSetting), 32'(PWR_SET_RST));
        check("drive reset", 32'(drive), 32'h0);
        axiRead(PWR_CTRL_ADDR, rdVal, resp);
        check("pmc reset", rdVal, 32'h0000_0000);
        axiRead(YDRV_ADDR, rdVal, resp);
        check("y sleep", rdVal, 32'(Y_READ_IDLE));

        // Every documented code in each field, then every mode
        for (int i = 0; i < 3; i++) begin
            wk = codes[i];
            sn = codes[2 - i];
            axiWrite(PWR_CTRL_ADDR, {24'h0, i[0], sn, 1'b0, wk}, 4'hF, resp);
            check("pmc wr resp", 32'(resp), 32'(RESP_OKAY));
            axiRead(PWR_CTRL_ADDR, rdVal, resp);
            check("pmc read", rdVal, {24'h0, 1'b0, sn, 1'b0, wk});
            check("hs enable", 32'(serialHighSpeedEnable), 32'(i[0]));
            foreach (modes[m]) begin
                setMode(modes[m]);
                check("aps mode", 32'(activePowerSetting), 32'((modes[m] == MODE_SNIFF) ? sn : wk));
                axiRead(YDRV_ADDR, rdVal, resp);
                check("y mode", rdVal, 32'((m < 2) ? Y_READ_IDLE : Y_READ_ACTIVE));
            end
        end

        axiWrite(PWR_CTRL_ADDR, 32'h0000_00FF, 4'hF, resp);
        axiRead(PWR_CTRL_ADDR, rdVal, resp);
        check("pmc all ones", rdVal, 32'h0000_0077);
        axiWrite(PWR_CTRL_ADDR, 32'h0000_0000, 4'h0, resp);
        axiRead(PWR_CTRL_ADDR, rdVal, resp);
        check("pmc no strobe", rdVal, 32'h0000_0077);

        foreach (drvData[k]) begin
            axiWrite(drvAddr[k], {24'h0, drvData[k]}, 4'h1, resp);
            check("drv resp", 32'(resp), 32'(RESP_OKAY));
            check("drive", 32'(drive), 32'(drvExp[k]));
            axiRead(YDRV_ADDR, rdVal, resp);
            check("y active", rdVal, 32'(Y_READ_ACTIVE));
        end

        axiRead(XDRV_ADDR, rdVal, resp);
        check("x read", rdVal, 32'h0000_0000);
        axiWrite(32'h0000_0074, 32'h0000_0000, 4'hF, resp);
        check("unmapped wr", 32'(resp), 32'(RESP_SLVERR));
        axiRead(32'h0000_0074, rdVal, resp);
        check("unmapped rd", 32'(resp), 32'(RESP_SLVERR));
        axiRead(PWR_CTRL_ADDR, rdVal, resp);
        check("pmc kept", rdVal, 32'h0000_0077);
        finalReport();
    end
endmodule
